// File: busmgmt_defs.svh
// constants for the instrument bus management controller
`ifndef BUSMGMT_DEFS_SVH
`define BUSMGMT_DEFS_SVH
`define SRQ_ENABLE_BIT 1
`define IE_MASK_RESET 8'h00
`define SYS_CTRL_RESET 1'b1
`define UNLISTEN_CMD 8'h3F
`define LISTEN_BASE 8'h20
`define TALK_BASE 8'h40
`define CMD_GTL 8'h01
`define CMD_SDC 8'h04
`define CMD_GET 8'h08
`define CMD_LLO 8'h11
`define CMD_DCL 8'h14
`endif

// File: busmgmt_pkg.sv
// types for the instrument bus management controller
package busmgmt_pkg;
	typedef enum logic [2:0]
	{
		OP_REMOTE,
		OP_LOCKOUT,
		OP_LOCAL,
		OP_TRIGGER,
		OP_CLEAR,
		OP_ABORT
	} op_e;
	typedef enum logic [1:0]
	{
		PH_UNL,
		PH_TALK,
		PH_LISTEN,
		PH_CMD
	} phase_e;
endpackage

// File: bus_mgmt_ctrl.sv
// controller-side bus management sequencer for an instrument bus
`timescale 1ns/1ps
`include "busmgmt_defs.svh"
// ****************************************************************
// Notes on behaviour
// ****************************************************************
// Notes on behaviour
// - remote enable asserted after reset and after every interface clear by system controller
// - remote request honoured only while system controller
// - lockout sent interface-wide, only while active controller
// - lockout cleared by interface-wide local; abort leaves lockout alone
// - addressed local sends go-to-local only to the named device
// - interface-wide local drops remote enable, clears lockout; system controller only
// - addressed local needs active controller role
// - interface trigger hits current listeners; addressed trigger only named device
// - no report of what a triggered instrument does
// - interface clear hits all devices; addressed clear only the named device
// - device clear needs active controller role
// - abort pulses interface clear; active or system controller only
// - abort by non-active system controller takes back active control
// - abort carrying a primary address is rejected
// - service interrupt only when handler defined and enable bit set
// - trigger from another controller detected while not active
// - attention asserted for address and command bytes, released for data
// - system controller becomes active controller at reset
// - addressing sends unlisten, talker, listener, then payload; addressed remote stops after listener
// - bit 1 of the enable mask enables service-request interrupts
module bus_mgmt_ctrl
	import busmgmt_pkg::*;
#(
	parameter int ADDR_W = 5
)
(
	input  wire logic              CLK,
	input  wire logic              ARST_N,
	input  wire logic              SYS_CTRL,
	input  wire logic              REQ_VALID,
	output logic                   REQ_READY,
	input  wire logic [2:0]        REQ_OP,
	input  wire logic              REQ_ADDRESSED,
	input  wire logic [ADDR_W-1:0] REQ_ADDR,
	input  wire logic [ADDR_W-1:0] MY_ADDR,
	output logic                   REQ_DONE,
	output logic                   REQ_REJECT,
	input  wire logic              PASS_CONTROL,
	input  wire logic              TAKE_CONTROL,
	input  wire logic              HANDLER_DEFINED,
	input  wire logic [7:0]        IE_MASK_WR,
	input  wire logic              IE_MASK_WE,
	output logic [7:0]             IE_MASK,
	input  wire logic              SRQ_IN,
	input  wire logic              TRIG_IN,
	output logic                   SRQ_IRQ,
	output logic                   TRIG_EVENT,
	output logic                   ACTIVE_CTRL,
	output logic                   LOCKOUT_ACTIVE,
	output logic                   REN_OUT,
	output logic                   IFC_OUT,
	output logic                   ATN_OUT,
	output logic [7:0]             BUS_BYTE,
	output logic                   BYTE_VALID,
	input  wire logic              BYTE_ACK
);
	// ****************************************************************
	// request decode and role checks
	// ****************************************************************
	typedef enum logic [1:0]
	{
		ST_IDLE,
		ST_SEND,
		ST_IFC
	} state_e;
	state_e state_q;
	phase_e phase_q;
	logic   active_q;
	logic   lockout_q;
	logic   ren_q;
	logic   ifc_q;
	logic   atn_q;
	logic   bvalid_q;
	logic   done_q;
	logic   reject_q;
	logic   irq_q;
	logic   trig_q;
	logic   addr_q;
	logic [7:0]        ie_q;
	logic [7:0]        byte_q;
	logic [7:0]        cmd_q;
	logic [ADDR_W-1:0] dev_q;
	logic [2:0]        op_q;
	logic allowed;
	logic take;
	logic [7:0] cmd_d;
	always_comb
	begin
		allowed = 1'b0;
		cmd_d = `CMD_GET;
		case (op_e'(REQ_OP))
			OP_REMOTE: allowed = SYS_CTRL;
			OP_LOCKOUT:
			begin
				allowed = active_q;
				cmd_d = `CMD_LLO;
			end
			OP_LOCAL:
			begin
				allowed = REQ_ADDRESSED ? active_q : SYS_CTRL;
				cmd_d = `CMD_GTL;
			end
			OP_TRIGGER: allowed = active_q;
			OP_CLEAR:
			begin
				allowed = active_q;
				cmd_d = REQ_ADDRESSED ? `CMD_SDC : `CMD_DCL;
			end
			OP_ABORT: allowed = (active_q | SYS_CTRL) & ~REQ_ADDRESSED;
			default: allowed = 1'b0;
		endcase
	end
	assign REQ_READY = (state_q == ST_IDLE);
	assign take = REQ_VALID & REQ_READY;
	// ****************************************************************
	// sequencer
	// ****************************************************************
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			state_q <= ST_IDLE;
			phase_q <= PH_UNL;
			cmd_q <= 8'h00;
			dev_q <= '0;
			op_q <= 3'h0;
			addr_q <= 1'b0;
			done_q <= 1'b0;
			reject_q <= 1'b0;
		end
		else
		begin
			done_q <= 1'b0;
			reject_q <= 1'b0;
			case (state_q)
				ST_IDLE:
					if (take)
					begin
						op_q <= REQ_OP;
						cmd_q <= cmd_d;
						dev_q <= REQ_ADDR;
						addr_q <= REQ_ADDRESSED;
						if (!allowed)
							reject_q <= 1'b1;
						else if (op_e'(REQ_OP) == OP_ABORT)
							state_q <= ST_IFC;
						else if ((op_e'(REQ_OP) == OP_REMOTE || op_e'(REQ_OP) == OP_LOCAL) && !REQ_ADDRESSED)
							done_q <= 1'b1;
						else
						begin
							state_q <= ST_SEND;
							phase_q <= (REQ_ADDRESSED && op_e'(REQ_OP) != OP_LOCKOUT) ? PH_UNL : PH_CMD;
						end
					end
				ST_SEND:
					if (BYTE_ACK && bvalid_q)
					begin
						case (phase_q)
							PH_UNL: phase_q <= PH_TALK;
							PH_TALK: phase_q <= PH_LISTEN;
							PH_LISTEN: phase_q <= PH_CMD;
							PH_CMD:
							begin
								state_q <= ST_IDLE;
								done_q <= 1'b1;
							end
							default: phase_q <= PH_UNL;
						endcase
						if (phase_q == PH_LISTEN && op_e'(op_q) == OP_REMOTE)
						begin
							state_q <= ST_IDLE; // addressing alone puts it remote
							done_q <= 1'b1;
						end
					end
				ST_IFC:
				begin
					state_q <= ST_IDLE;
					done_q <= 1'b1;
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end
	// ****************************************************************
	// bus byte output, attention always set for commands
	// ****************************************************************
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			bvalid_q <= 1'b0;
			byte_q <= 8'h00;
			atn_q <= 1'b0;
		end
		else if (state_q == ST_SEND && !(bvalid_q && BYTE_ACK))
		begin
			bvalid_q <= 1'b1;
			atn_q <= 1'b1; // every byte here is a command
			case (phase_q)
				PH_UNL: byte_q <= `UNLISTEN_CMD;
				PH_TALK: byte_q <= `TALK_BASE | {3'b000, MY_ADDR};
				PH_LISTEN: byte_q <= `LISTEN_BASE | {3'b000, dev_q};
				PH_CMD: byte_q <= cmd_q;
				default: byte_q <= 8'h00;
			endcase
		end
		else
		begin
			bvalid_q <= 1'b0;
			atn_q <= 1'b0;
		end
	end
	// ****************************************************************
	// roles, remote enable, lockout, interface clear
	// ****************************************************************
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			active_q <= `SYS_CTRL_RESET;
			ren_q <= `SYS_CTRL_RESET;
			ifc_q <= 1'b0;
		end
		else
		begin
			ifc_q <= 1'b0;
			if (take && allowed && op_e'(REQ_OP) == OP_ABORT)
			begin
				ifc_q <= 1'b1;
				if (SYS_CTRL)
				begin
					active_q <= 1'b1;
					ren_q <= 1'b1;
				end
			end
			else if (take && allowed && op_e'(REQ_OP) == OP_REMOTE)
				ren_q <= 1'b1;
			else if (take && allowed && op_e'(REQ_OP) == OP_LOCAL && !REQ_ADDRESSED)
				ren_q <= 1'b0;
			else if (PASS_CONTROL && state_q == ST_IDLE)
				active_q <= 1'b0;
			else if (TAKE_CONTROL)
				active_q <= 1'b1;
		end
	end
	// lockout stays across abort; only interface-wide local drops it
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			lockout_q <= 1'b0;
		else if (take && allowed && op_e'(REQ_OP) == OP_LOCAL && !REQ_ADDRESSED)
			lockout_q <= 1'b0;
		else if (take && allowed && op_e'(REQ_OP) == OP_LOCKOUT)
			lockout_q <= 1'b1;
	end
	// ****************************************************************
	// service request and trigger detection
	// ****************************************************************
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			ie_q <= `IE_MASK_RESET;
			irq_q <= 1'b0;
			trig_q <= 1'b0;
		end
		else
		begin
			if (IE_MASK_WE)
				ie_q <= IE_MASK_WR;
			// level sensitive: a short pulse between edges is not seen
			irq_q <= SRQ_IN & active_q & HANDLER_DEFINED & ie_q[`SRQ_ENABLE_BIT];
			trig_q <= TRIG_IN & ~active_q;
		end
	end
	assign SRQ_IRQ = irq_q;
	assign TRIG_EVENT = trig_q;
	assign IE_MASK = ie_q;
	assign ACTIVE_CTRL = active_q;
	assign LOCKOUT_ACTIVE = lockout_q;
	assign REN_OUT = ren_q;
	assign IFC_OUT = ifc_q;
	assign ATN_OUT = atn_q;
	assign BUS_BYTE = byte_q;
	assign BYTE_VALID = bvalid_q;
	assign REQ_DONE = done_q;
	assign REQ_REJECT = reject_q;
	// ****************************************************************
	// checks
	// ****************************************************************
	a_remote_role: assert property (@(posedge CLK) disable iff (!ARST_N)
		(take && op_e'(REQ_OP) == OP_REMOTE && !SYS_CTRL) |=> REQ_REJECT)
		else $error("remote accepted without system role");
	a_abort_addr: assert property (@(posedge CLK) disable iff (!ARST_N)
		(take && op_e'(REQ_OP) == OP_ABORT && REQ_ADDRESSED) |=> (REQ_REJECT && !IFC_OUT))
		else $error("addressed abort not rejected");
	a_abort_regain: assert property (@(posedge CLK) disable iff (!ARST_N)
		(take && op_e'(REQ_OP) == OP_ABORT && !REQ_ADDRESSED && SYS_CTRL) |=> (ACTIVE_CTRL && IFC_OUT && REN_OUT))
		else $error("abort did not regain control");
	a_lockout_keep: assert property (@(posedge CLK) disable iff (!ARST_N)
		IFC_OUT |-> (LOCKOUT_ACTIVE == $past(LOCKOUT_ACTIVE)))
		else $error("abort cleared lockout");
	a_lockout_set: assert property (@(posedge CLK) disable iff (!ARST_N)
		$rose(LOCKOUT_ACTIVE) |-> $past(active_q))
		else $error("lockout set without active role");
	a_clear_role: assert property (@(posedge CLK) disable iff (!ARST_N)
		(take && op_e'(REQ_OP) == OP_CLEAR && !active_q) |=> REQ_REJECT)
		else $error("clear accepted without active role");
	sequence s_unl;
		BYTE_VALID && BUS_BYTE == `UNLISTEN_CMD && BYTE_ACK;
	endsequence
	sequence s_talk;
		##[1:4] (BYTE_VALID && (BUS_BYTE & 8'hE0) == `TALK_BASE);
	endsequence
	a_addr_order: assert property (@(posedge CLK) disable iff (!ARST_N)
		s_unl |-> s_talk)
		else $error("talker not after unlisten");
	a_atn_cmd: assert property (@(posedge CLK) disable iff (!ARST_N)
		ATN_OUT == BYTE_VALID)
		else $error("command byte without attention");
	a_srq_gate: assert property (@(posedge CLK) disable iff (!ARST_N)
		SRQ_IRQ |-> ($past(HANDLER_DEFINED) && $past(ie_q[`SRQ_ENABLE_BIT])))
		else $error("service interrupt while disabled");
	a_trig_detect: assert property (@(posedge CLK) disable iff (!ARST_N)
		(TRIG_IN && !active_q) |=> TRIG_EVENT)
		else $error("foreign trigger missed");
endmodule

// File: bus_instr_model.sv
// instrument-side model: byte acceptor plus service and trigger sources
`timescale 1ns/1ps
module bus_instr_model
#(
	parameter logic [7:0] LISTEN_CODE = 8'h00
)
(
	input  wire logic       clk,
	input  wire logic       arst_n,
	input  wire logic       byte_valid,
	output logic            byte_ack,
	input  wire logic [3:0] ack_wait,
	input  wire logic       srq_want,
	input  wire logic       trig_want,
	output logic            srq_line,
	output logic            trig_line,
	input  wire logic [7:0] bus_byte,
	input  wire logic       lockout,
	input  wire logic       local_key,
	output logic            in_remote
);
	logic [3:0] wait_q;
	// ****************
	// byte handshake
	// ****************
	// slow listeners stretch each byte by ack_wait cycles
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			byte_ack <= 1'b0;
			wait_q   <= 4'h0;
		end
		else if (byte_ack)
		begin
			byte_ack <= 1'b0;
			wait_q   <= 4'h0;
		end
		else if (byte_valid)
		begin
			if (wait_q == ack_wait)
				byte_ack <= 1'b1;
			else
				wait_q <= wait_q + 4'h1;
		end
	end
	// level follows srq_want one cycle later
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			srq_line <= 1'b0;
		else
			srq_line <= srq_want;
	end
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			trig_line <= 1'b0;
		else
			trig_line <= trig_want;
	end
	// front-panel state of the instrument at LISTEN_CODE
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			in_remote <= 1'b0;
		else if (byte_valid && byte_ack && bus_byte == LISTEN_CODE)
			in_remote <= 1'b1;
		else if (local_key && !lockout)
			in_remote <= 1'b0;
	end
endmodule

// File: test_instrument_bus_management_controller.sv
// self-checking bench for the bus management controller
`timescale 1ns/1ps
`include "busmgmt_defs.svh"
module test_instrument_bus_management_controller
	import busmgmt_pkg::*;
;
	logic clk, arst_n, req_valid, req_ready, req_addressed, req_done, req_reject;
	logic pass_c, take_c, handler, ie_we, srq_in, trig_in, srq_irq, trig_event;
	logic active, lockout, ren, ifc_out, atn_out, byte_valid, byte_ack, srq_want, trig_want;
	logic sys_ctrl, local_key, in_remote;
	logic [2:0] req_op;
	logic [4:0] req_addr;
	logic [4:0] my_addr;
	logic [7:0] ie_wr, ie_mask, bus_byte;
	logic [3:0] ack_wait;
	logic [7:0] bq[8];
	int nb, n_fail, compares;
	logic done, rej, ifc, atn_ok;
	bus_mgmt_ctrl i_bus_mgmt_ctrl (.CLK(clk), .ARST_N(arst_n), .SYS_CTRL(sys_ctrl), .REQ_VALID(req_valid),
		.REQ_READY(req_ready), .REQ_OP(req_op), .REQ_ADDRESSED(req_addressed), .REQ_ADDR(req_addr),
		.MY_ADDR(my_addr), .REQ_DONE(req_done), .REQ_REJECT(req_reject), .PASS_CONTROL(pass_c),
		.TAKE_CONTROL(take_c), .HANDLER_DEFINED(handler), .IE_MASK_WR(ie_wr), .IE_MASK_WE(ie_we),
		.IE_MASK(ie_mask), .SRQ_IN(srq_in), .TRIG_IN(trig_in), .SRQ_IRQ(srq_irq), .TRIG_EVENT(trig_event),
		.ACTIVE_CTRL(active), .LOCKOUT_ACTIVE(lockout), .REN_OUT(ren), .IFC_OUT(ifc_out),
		.ATN_OUT(atn_out), .BUS_BYTE(bus_byte), .BYTE_VALID(byte_valid), .BYTE_ACK(byte_ack));
	bus_instr_model #(.LISTEN_CODE(`LISTEN_BASE | 8'h07)) i_bus_instr_model (.clk(clk), .arst_n(arst_n),
		.byte_valid(byte_valid), .byte_ack(byte_ack), .ack_wait(ack_wait), .srq_want(srq_want),
		.trig_want(trig_want), .srq_line(srq_in), .trig_line(trig_in), .bus_byte(bus_byte),
		.lockout(lockout), .local_key(local_key), .in_remote(in_remote));
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// ****************
	// shared tasks
	// ****************
	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		compares++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, exp);
		end
	endtask
	task automatic req(input logic [2:0] op, input logic ad, input logic [4:0] a);
		nb = 0;
		done = 1'b0;
		rej = 1'b0;
		ifc = 1'b0;
		atn_ok = 1'b1;
		@(posedge clk);
		req_valid <= 1'b1;
		req_op <= op;
		req_addressed <= ad;
		req_addr <= a;
		@(posedge clk);
		req_valid <= 1'b0;
		for (int i = 0; i < 200 && !(done || rej); i++)
		begin
			@(negedge clk);
			if (byte_valid === 1'b1 && byte_ack === 1'b1 && nb < 8)
			begin
				bq[nb] = bus_byte;
				nb++;
				atn_ok = atn_ok & (atn_out === 1'b1);
			end
			ifc = ifc | (ifc_out === 1'b1);
			done = (req_done === 1'b1);
			rej = (req_reject === 1'b1);
		end
		check({15'h0000, done | rej}, 16'h0001, "request finished");
	endtask
	task automatic ctl(input logic take);
		@(posedge clk);
		take_c <= take;
		pass_c <= !take;
		@(posedge clk);
		take_c <= 1'b0;
		pass_c <= 1'b0;
		@(negedge clk);
	endtask
	task automatic key_press;
		@(posedge clk);
		local_key <= 1'b1;
		@(posedge clk);
		local_key <= 1'b0;
		@(negedge clk);
	endtask
	task automatic complete_run;
		$display("counts: compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// ****************
	// scenarios
	// ****************
	task automatic t_reset;
		check(active, 1'b1, "active at reset");
		check(ren, 1'b1, "remote enable at reset");
		check(lockout, 1'b0, "lockout at reset");
		check(in_remote, 1'b0, "instrument local at reset");
		$display("test reset done");
	endtask
	task automatic t_addressed;
		logic [2:0] ops[3] = '{3'(OP_CLEAR), 3'(OP_TRIGGER), 3'(OP_LOCAL)};
		logic [7:0] cmd[3] = '{`CMD_SDC, `CMD_GET, `CMD_GTL};
		for (int k = 0; k < 3; k++)
		begin
			ack_wait <= 4'(k * 3);
			req(ops[k], 1'b1, 5'h07);
			check(8'(nb), 8'h04, "addressed byte count");
			check(bq[0], `UNLISTEN_CMD, "unlisten");
			check(bq[1], `TALK_BASE | {3'h0, my_addr}, "talker");
			check(bq[2], `LISTEN_BASE | 8'h07, "listener");
			check(bq[3], cmd[k], "command");
			check(atn_ok, 1'b1, "attention on commands");
			check(done, 1'b1, "addressed done");
		end
		req(3'(OP_REMOTE), 1'b1, 5'h07);
		check(8'(nb), 8'h03, "addressed remote byte count");
		check(bq[2], `LISTEN_BASE | 8'h07, "remote listener");
		check(done, 1'b1, "addressed remote done");
		check(in_remote, 1'b1, "addressed instrument remote");
		$display("test addressed done");
	endtask
	task automatic t_broadcast;
		logic [2:0] ops[3] = '{3'(OP_LOCKOUT), 3'(OP_TRIGGER), 3'(OP_CLEAR)};
		logic [7:0] cmd[3] = '{`CMD_LLO, `CMD_GET, `CMD_DCL};
		for (int k = 0; k < 3; k++)
		begin
			req(ops[k], 1'b0, 5'h00);
			check(8'(nb), 8'h01, "broadcast byte count");
			check(bq[0], cmd[k], "broadcast command");
		end
		check(lockout, 1'b1, "lockout set");
		req(3'(OP_ABORT), 1'b1, 5'h04);
		check(rej, 1'b1, "addressed abort refused");
		req(3'(OP_ABORT), 1'b0, 5'h00);
		check(ifc & done, 1'b1, "abort clears interface");
		check(lockout, 1'b1, "abort keeps lockout");
		key_press();
		check(in_remote, 1'b1, "key ignored under lockout");
		req(3'(OP_LOCAL), 1'b0, 5'h00);
		check({done, ren, lockout, 8'(nb)}, 11'h400, "interface local");
		key_press();
		check(in_remote, 1'b0, "key returns local");
		req(3'(OP_REMOTE), 1'b0, 5'h00);
		check({done, ren}, 2'b11, "remote again");
		$display("test broadcast done");
	endtask
	task automatic t_roles;
		ctl(1'b0);
		check(active, 1'b0, "pass control");
		trig_want <= 1'b1;
		repeat (3) @(negedge clk);
		check(trig_event, 1'b1, "trigger from other controller");
		trig_want <= 1'b0;
		req(3'(OP_LOCKOUT), 1'b0, 5'h00);
		check({rej, 8'(nb)}, 9'h100, "lockout refused");
		req(3'(OP_CLEAR), 1'b1, 5'h02);
		check({rej, 8'(nb)}, 9'h100, "clear refused");
		req(3'(OP_LOCAL), 1'b1, 5'h02);
		check(rej, 1'b1, "addressed local refused");
		ctl(1'b1);
		check(active, 1'b1, "take control");
		ctl(1'b0);
		req(3'(OP_LOCAL), 1'b0, 5'h00);
		check({done, ren}, 2'b10, "interface local as non-active system");
		req(3'(OP_ABORT), 1'b0, 5'h00);
		check({ifc, active, ren}, 3'b111, "abort regains control");
		@(posedge clk);
		sys_ctrl <= 1'b0;
		req(3'(OP_REMOTE), 1'b0, 5'h00);
		check(rej, 1'b1, "remote refused without system role");
		req(3'(OP_LOCAL), 1'b0, 5'h00);
		check({rej, lockout}, 2'b10, "interface local refused without system role");
		ctl(1'b0);
		req(3'(OP_ABORT), 1'b0, 5'h00);
		check({rej, ifc, active}, 3'b100, "abort refused without any role");
		ctl(1'b1);
		@(posedge clk);
		sys_ctrl <= 1'b1;
		$display("test roles done");
	endtask
	task automatic t_srq;
		@(posedge clk);
		ie_we <= 1'b1;
		ie_wr <= 8'h02;
		@(posedge clk);
		ie_we <= 1'b0;
		handler <= 1'b1;
		srq_want <= 1'b1;
		repeat (3) @(negedge clk);
		check(ie_mask, 8'h02, "enable mask");
		check(srq_irq, 1'b1, "service interrupt");
		@(posedge clk);
		handler <= 1'b0;
		repeat (2) @(negedge clk);
		check(srq_irq, 1'b0, "no handler");
		@(posedge clk);
		handler <= 1'b1;
		ie_we <= 1'b1;
		ie_wr <= 8'hFD;
		@(posedge clk);
		ie_we <= 1'b0;
		repeat (3) @(negedge clk);
		check(srq_irq, 1'b0, "bit masked");
		srq_want <= 1'b0;
		$display("test srq done");
	endtask
	initial
	begin
		#20000;
		n_fail++;
		complete_run();
	end
	initial
	begin
		{arst_n, req_valid, req_addressed, pass_c, take_c, handler, ie_we, srq_want, trig_want, local_key} = '0;
		sys_ctrl = 1'b1;
		{req_op, req_addr, ie_wr, ack_wait, n_fail, compares} = '0;
		my_addr = 5'h03;
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		@(negedge clk);
		t_reset();
		t_addressed();
		t_broadcast();
		t_roles();
		t_srq();
		complete_run();
	end
endmodule
